// ---- pkg/pors_consts.vh ----
/*
  Constants for the power-on reset sequencer: counts, widths, reset values.
  Assumes inclusion once per compilation unit by its bare name.
*/
`ifndef PORS_CONSTS_VH
`define PORS_CONSTS_VH

`define PORS_WDT_CYCLES     10'h202
`define PORS_WDT_W          10
`define PORS_SETTLE_CYCLES  5'h10
`define PORS_SETTLE_W       5
`define PORS_STATUS_RST     1'h0
`define PORS_STATUS_SET     1'h1
`define PORS_WDT_STEP       10'h001
`define PORS_SETTLE_STEP    5'h01
`define PORS_FETCH_RST      1'h0
`define PORS_HOLD_RST       1'h1

`endif

// ---- verilog/pors_sequencer.v ----
/*
  Power-on reset sequencer: holds the core in reset until supply is good,
  then 514 watchdog-oscillator ticks and 16 system clocks have passed.
  Gives a one-cycle vector-fetch strobe and a power-on status flag.
  Assumes all inputs synchronous to ref_clk_i; the watchdog oscillator
  arrives as a one-cycle tick pulse, not as a clock.
  Assumes the reset pin and supply indication are already filtered;
  any low pin or bad supply sample restarts the whole sequence.
*/
`timescale 1ns/1ps
`include "pors_consts.vh"

// Notes on behaviour
// [RULE1] Low reset pin forces and holds reset
// [RULE2] Supply below threshold keeps device in reset
// [RULE3] Supply good starts 514 watchdog-oscillator tick count
// [RULE4] Then count 16 system clocks for settling
// [RULE5] Reset held until both counts complete
// [RULE6] Release lets processor fetch reset vector
// [RULE7] Completed power-on reset sets status flag
// [RULE8] Supply drop or pin reassert restarts sequence
module pors_sequencer
(
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // Partner side
  input  wire        ext_reset_n_i,
  input  wire        supply_good_i,
  input  wire        wdt_osc_tick_i,
  // Status clear from watchdog_control_reg write
  input  wire        por_status_clr_i,
  // Core side
  output wire        core_reset_o,
  output wire        fetch_vector_o,
  output wire        por_status_o,
  output wire [2:0]  seq_state_o
);

  //--------------------------------------------------
  // States
  //--------------------------------------------------
  localparam [2:0] ST_HOLD   = 3'h1;
  localparam [2:0] ST_SETTLE = 3'h2;
  localparam [2:0] ST_RUN    = 3'h4;

  //--------------------------------------------------
  // Sequence and output state
  //--------------------------------------------------
  reg  [2:0]                 state_r;
  reg  [2:0]                 state_nxt;
  reg  [`PORS_WDT_W-1:0]     wdt_cnt_r;
  reg  [`PORS_WDT_W-1:0]     wdt_cnt_nxt;
  reg  [`PORS_SETTLE_W-1:0]  set_cnt_r;
  reg  [`PORS_SETTLE_W-1:0]  set_cnt_nxt;
  reg                        status_r;
  reg                        status_nxt;
  reg                        fetch_r;
  reg                        fetch_nxt;
  reg                        core_reset_r;
  reg                        core_reset_nxt;
  wire                       abort;
  wire                       run_entry;

  //--------------------------------------------------
  // Helpers
  //--------------------------------------------------
  // Last watchdog tick of the start-up delay
  function wdt_last;
    input [`PORS_WDT_W-1:0] cnt;
    begin
      wdt_last = (cnt == (`PORS_WDT_CYCLES - `PORS_WDT_STEP));
    end
  endfunction

  // Last system clock of the settle delay
  function settle_last;
    input [`PORS_SETTLE_W-1:0] cnt;
    begin
      settle_last = (cnt == (`PORS_SETTLE_CYCLES - `PORS_SETTLE_STEP));
    end
  endfunction

  // Step from any other state into run
  function enters_run;
    input [2:0] cur;
    input [2:0] nxt;
    begin
      enters_run = (cur != ST_RUN) && (nxt == ST_RUN);
    end
  endfunction

  assign abort     = ~ext_reset_n_i | ~supply_good_i; // RULE1 RULE2
  assign run_entry = enters_run(state_r, state_nxt);

  //--------------------------------------------------
  // Next state
  //--------------------------------------------------
  always @*
  begin
    state_nxt   = state_r;
    wdt_cnt_nxt = wdt_cnt_r;
    set_cnt_nxt = set_cnt_r;
    case (state_r)
      ST_HOLD:
      begin
        if (wdt_osc_tick_i)
        begin
          if (wdt_last(wdt_cnt_r))
          begin
            wdt_cnt_nxt = {`PORS_WDT_W{1'b0}};
            state_nxt   = ST_SETTLE; // RULE4
          end
          else
          begin
            wdt_cnt_nxt = wdt_cnt_r + `PORS_WDT_STEP; // RULE3
          end
        end
      end
      ST_SETTLE:
      begin
        if (settle_last(set_cnt_r))
        begin
          set_cnt_nxt = {`PORS_SETTLE_W{1'b0}};
          state_nxt   = ST_RUN; // RULE5
        end
        else
        begin
          set_cnt_nxt = set_cnt_r + `PORS_SETTLE_STEP; // RULE4
        end
      end
      ST_RUN:
      begin
        state_nxt = ST_RUN;
      end
      default:
      begin
        state_nxt = ST_HOLD;
      end
    endcase
    // Abort wins over any count progress
    if (abort)
    begin
      state_nxt   = ST_HOLD; // RULE8
      wdt_cnt_nxt = {`PORS_WDT_W{1'b0}};
      set_cnt_nxt = {`PORS_SETTLE_W{1'b0}};
    end
  end

  //--------------------------------------------------
  // Output next values
  //--------------------------------------------------
  // Set wins over a clear in the same cycle
  always @*
  begin
    status_nxt = status_r;
    if (run_entry)
    begin
      status_nxt = `PORS_STATUS_SET; // RULE7
    end
    else if (por_status_clr_i)
    begin
      status_nxt = `PORS_STATUS_RST;
    end
  end

  always @*
  begin
    fetch_nxt = run_entry; // RULE6
  end

  // Registered so the core reset never glitches
  always @*
  begin
    core_reset_nxt = (state_nxt != ST_RUN); // RULE5
  end

  //--------------------------------------------------
  // Sequence registers
  //--------------------------------------------------
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r   <= ST_HOLD;
      wdt_cnt_r <= {`PORS_WDT_W{1'b0}};
      set_cnt_r <= {`PORS_SETTLE_W{1'b0}};
    end
    else
    begin
      state_r   <= state_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      set_cnt_r <= set_cnt_nxt;
    end
  end

  //--------------------------------------------------
  // Output registers
  //--------------------------------------------------
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_r     <= `PORS_STATUS_RST;
      fetch_r      <= `PORS_FETCH_RST;
      core_reset_r <= `PORS_HOLD_RST;
    end
    else
    begin
      status_r     <= status_nxt;
      fetch_r      <= fetch_nxt;
      core_reset_r <= core_reset_nxt;
    end
  end

  //--------------------------------------------------
  // Outputs
  //--------------------------------------------------
  assign core_reset_o   = core_reset_r;
  assign fetch_vector_o = fetch_r;
  assign por_status_o   = status_r;
  assign seq_state_o    = state_r;

endmodule // pors_sequencer

// ---- tb/pors_sva.sv ----
/* Port checker for pors_sequencer.
   Assumes the bind below and one clock domain. */
`timescale 1ns/1ps
module pors_sva
(
  input wire       ref_clk_i,
  input wire       rst_i,
  input wire       ext_reset_n_i,
  input wire       supply_good_i,
  input wire       wdt_osc_tick_i,
  input wire       por_status_clr_i,
  input wire       core_reset_o,
  input wire       fetch_vector_o,
  input wire       por_status_o,
  input wire [2:0] seq_state_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_pin_hold: assert property (!ext_reset_n_i |=> core_reset_o) else $error("pin");
  a_supply_hold: assert property (!supply_good_i |=> core_reset_o) else $error("supply");
  a_tick_end: assert property ($rose(seq_state_o[1]) |-> $past(wdt_osc_tick_i)) else $error("tick");
  a_settle_len: assert property ($rose(seq_state_o[2]) |->
    $past(seq_state_o, 16) == 3'h2 && $past(seq_state_o, 17) == 3'h1) else $error("settle");
  a_run_only: assert property (!core_reset_o |-> seq_state_o == 3'h4) else $error("run");
  a_fetch_once: assert property ($rose(seq_state_o[2]) |-> fetch_vector_o ##1 !fetch_vector_o)
    else $error("fetch");
  a_fetch_entry: assert property (fetch_vector_o |-> $rose(seq_state_o[2])) else $error("fetch entry");
  a_status_set: assert property ($rose(seq_state_o[2]) |-> por_status_o) else $error("status");
  a_status_keep: assert property (por_status_o && !por_status_clr_i |=> por_status_o)
    else $error("status lost");
  a_seq_restart: assert property ((!ext_reset_n_i || !supply_good_i) |=> seq_state_o == 3'h1)
    else $error("restart");
endmodule // pors_sva
bind pors_sequencer pors_sva pors_sva_i
(
  .ref_clk_i        (ref_clk_i),
  .rst_i            (rst_i),
  .ext_reset_n_i    (ext_reset_n_i),
  .supply_good_i    (supply_good_i),
  .wdt_osc_tick_i   (wdt_osc_tick_i),
  .por_status_clr_i (por_status_clr_i),
  .core_reset_o     (core_reset_o),
  .fetch_vector_o   (fetch_vector_o),
  .por_status_o     (por_status_o),
  .seq_state_o      (seq_state_o)
);

// ---- tb/pors_partner.sv ----
/* Supply detector and reset pin model.
   Assumes ctl_i changes at the falling edge. */
`timescale 1ns/1ps
module pors_partner
(
  input  wire [2:0] ctl_i,
  output wire       supply_good_o,
  output wire       ext_reset_n_o,
  output wire       wdt_osc_tick_o
);
  assign {supply_good_o, ext_reset_n_o, wdt_osc_tick_o} = ctl_i;
endmodule // pors_partner

// ---- tb/testbench.sv ----
/* Bench for pors_sequencer.
   Assumes pors_partner and pors_sva compiled first. */
`timescale 1ns/1ps
module testbench;
  reg        ref_clk_i = 0;
  reg        rst_i = 1;
  reg  [2:0] ctl_i = 3'h0;
  reg        por_status_clr_i = 0;
  wire       supply_good_i, ext_reset_n_i, wdt_osc_tick_i, core_reset_o, fetch_vector_o, por_status_o;
  wire [2:0] seq_state_o;
  integer    err_count = 0;
  integer    n_compared = 0;
  pors_partner pors_partner_i (.ctl_i(ctl_i), .supply_good_o(supply_good_i), .ext_reset_n_o(ext_reset_n_i),
    .wdt_osc_tick_o(wdt_osc_tick_i));
  pors_sequencer pors_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i),
    .supply_good_i(supply_good_i), .wdt_osc_tick_i(wdt_osc_tick_i), .por_status_clr_i(por_status_clr_i),
    .core_reset_o(core_reset_o), .fetch_vector_o(fetch_vector_o), .por_status_o(por_status_o),
    .seq_state_o(seq_state_o));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  task wt(input integer n, input [5:0] e);
  begin
    repeat (n) @(negedge ref_clk_i);
    n_compared = n_compared + 1;
    if ({core_reset_o, fetch_vector_o, por_status_o, seq_state_o} !== e)
    begin
      err_count = err_count + 1;
      $display("ERROR %0t got %h exp %h", $time, {core_reset_o, fetch_vector_o, por_status_o, seq_state_o}, e);
    end
  end
  endtask
  task full_run(input s);
  begin
    ctl_i = 3'h7;
    wt(513, {2'h2, s, 3'h1});
    wt(1, {2'h2, s, 3'h2});
    wt(15, {2'h2, s, 3'h2});
    wt(1, 6'h1C);
    wt(1, 6'h0C);
    wt(1, 6'h0C);
  end
  endtask
  task abort_at(input integer n, input [5:0] e);
  begin
    ctl_i = 3'h7;
    wt(n, e);
    ctl_i = 3'h3;
    wt(1, 6'h29);
  end
  endtask
  task supply_low_hold;
  begin
    ctl_i = 3'h3;
    wt(600, 6'h21);
  end
  endtask
  task pin_abort;
  begin
    ctl_i = 3'h5;
    wt(1, 6'h29);
  end
  endtask
  task tick_gap;
  begin
    ctl_i = 3'h6;
    wt(50, 6'h29);
  end
  endtask
  task status_clear;
  begin
    por_status_clr_i = 1;
    wt(1, 6'h04);
    por_status_clr_i = 0;
    wt(1, 6'h04);
  end
  endtask
  task mid_reset;
  begin
    rst_i = 1;
    wt(2, 6'h21);
    rst_i = 0;
  end
  endtask
  task conclude;
  begin
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (12) @(negedge ref_clk_i);
    rst_i = 0;
    wt(1, 6'h21);
    supply_low_hold;
    full_run(0);
    pin_abort;
    abort_at(300, 6'h29);
    abort_at(520, 6'h2A);
    tick_gap;
    full_run(1);
    status_clear;
    mid_reset;
    full_run(0);
    conclude;
  end
  initial
  begin
    #250000;
    err_count = err_count + 1;
    conclude;
  end
endmodule // testbench
